// ---- hw/ccc_top.sv ----
// Comparator and converter digital control with local register port
`timescale 1ns/10ps
module ccc_top (
   // Clock and reset
   input  wire logic       ref_clk_i,
   input  wire logic       nrst_i,
   // Register port
   input  wire logic [7:0] addr_i,
   input  wire logic [7:0] wdata_i,
   input  wire logic       wr_i,
   input  wire logic       rd_i,
   output logic      [7:0] rdata_o,
   // Interrupt controller
   input  wire logic       global_irq_enable_i,
   input  wire logic       cmp_vector_ack_i,
   output logic            cmp_irq_o,
   output logic            conv_irq_o,
   // Comparator and pins
   input  wire logic       cmp_analog_i,
   input  wire logic       cmp_positive_pin_i,
   input  wire logic       cmp_negative_pin_i,
   output logic            pos_pin_port_o,
   output logic            neg_pin_port_o,
   output logic            pos_pin_buffer_on_o,
   output logic            neg_pin_buffer_on_o,
   output logic            capture_input_o,
   output logic            use_mux_negative_o,
   output logic      [2:0] mux_negative_chan_o,
   // Converter analog core
   input  wire logic       conv_done_i,
   input  wire logic [9:0] conv_result_i,
   output logic            conv_active_o,
   output logic      [1:0] reference_select_o,
   output logic      [5:0] channel_select_o,
   output logic      [1:0] gain_o
);
   // ==========================================================================================
   // State
   typedef struct packed {
      logic [2:0] pin_meta;      // raw synchronised comparator, pos, neg pins from child
      logic       cmp_prev;
      logic       cmp_irq_enable;
      logic       cmp_irq_flag;
      logic       cmp_capture_route;
      logic [1:0] cmp_event_select;
      logic       cmp_negative_mux_enable;
      logic       pos_pin_input_off;
      logic       neg_pin_input_off;
      logic       conv_enable;
      logic       conv_irq_flag;
      logic       conv_irq_enable;
      logic [1:0] reference_select;
      logic       result_left_align;
      logic [5:0] channel_select;
      logic       conv_power_gate;
      logic [9:0] result;
      logic       result_locked;
      logic [7:0] rdata;
      logic [1:0] eff_reference;
      logic [5:0] eff_channel;
   } ccc_state_t;

   ccc_state_t state;
   ccc_state_t next_state;
   logic [2:0] pins_sync;
   logic       cmp_sync_output;
   logic       cmp_event;
   logic       conv_active;
   logic [7:0] res_low;
   logic [7:0] res_high;

   // ==========================================================================================
   // Input synchronisers
   ccc_sync #(
      .WIDTH (3)
   ) u_sync (
      .ref_clk_i (ref_clk_i),
      .nrst_i    (nrst_i),
      .async_i   ({cmp_analog_i, cmp_positive_pin_i, cmp_negative_pin_i}),
      .sync_o    (pins_sync)
   );

   // Channel and gain decode
   ccc_chan_decode u_decode (
      .channel_select_i          (state.eff_channel),
      .conv_enable_i             (state.conv_enable),
      .cmp_negative_mux_enable_i (state.cmp_negative_mux_enable),
      .use_mux_negative_o        (use_mux_negative_o),
      .mux_negative_chan_o       (mux_negative_chan_o),
      .gain_o                    (gain_o)
   );

   // Byte views of the result, aligned per alignment bit
   function automatic logic [15:0] ccc_align(input logic [9:0] res, input logic left);
      if (left) begin
         ccc_align = {res, 6'h00};
      end else begin
         ccc_align = {6'h00, res};
      end
   endfunction

   always_comb begin
      {res_high, res_low} = ccc_align(state.result, state.result_left_align);
   end

   // Comparator event detection
   always_comb begin
      cmp_sync_output = pins_sync[2];
      case (state.cmp_event_select)
         ccc_pkg::CCC_EVT_TOGGLE:  cmp_event = cmp_sync_output != state.cmp_prev;
         ccc_pkg::CCC_EVT_FALLING: cmp_event = !cmp_sync_output && state.cmp_prev;
         ccc_pkg::CCC_EVT_RISING:  cmp_event = cmp_sync_output && !state.cmp_prev;
         default:                  cmp_event = 1'b0;
      endcase
      conv_active = state.conv_enable && !state.conv_power_gate;
   end

   // Next-state logic
   always_comb begin
      next_state          = state;
      next_state.pin_meta = pins_sync;
      next_state.cmp_prev = cmp_sync_output;
      next_state.rdata    = ccc_pkg::CCC_RESET_BYTE;

      // Register writes
      if (wr_i) begin
         case (addr_i)
            ccc_pkg::CCC_ADDR_CMP_CTRL: begin
               next_state.cmp_irq_enable    = wdata_i[ccc_pkg::CCC_CMP_IRQ_ENABLE_BIT];
               next_state.cmp_capture_route = wdata_i[ccc_pkg::CCC_CMP_CAPTURE_BIT];
               next_state.cmp_event_select  =
                  wdata_i[ccc_pkg::CCC_CMP_EVENT_LSB +: 2];
               if (wdata_i[ccc_pkg::CCC_CMP_IRQ_FLAG_BIT]) begin
                  next_state.cmp_irq_flag = 1'b0;
               end
            end
            ccc_pkg::CCC_ADDR_CONV_CTRL_B: begin
               next_state.cmp_negative_mux_enable =
                  wdata_i[ccc_pkg::CCC_CMP_MUX_ENABLE_BIT];
            end
            ccc_pkg::CCC_ADDR_PIN_DISABLE: begin
               next_state.pos_pin_input_off = wdata_i[ccc_pkg::CCC_POS_PIN_OFF_BIT];
               next_state.neg_pin_input_off = wdata_i[ccc_pkg::CCC_NEG_PIN_OFF_BIT];
            end
            ccc_pkg::CCC_ADDR_CONV_CTRL_A: begin
               next_state.conv_enable     = wdata_i[ccc_pkg::CCC_CONV_ENABLE_BIT];
               next_state.conv_irq_enable = wdata_i[ccc_pkg::CCC_CONV_IRQ_ENABLE_BIT];
               if (wdata_i[ccc_pkg::CCC_CONV_IRQ_FLAG_BIT]) begin
                  next_state.conv_irq_flag = 1'b0;
               end
            end
            ccc_pkg::CCC_ADDR_CHAN_REF: begin
               next_state.reference_select  = wdata_i[ccc_pkg::CCC_REF_SELECT_LSB +: 2];
               next_state.result_left_align = wdata_i[ccc_pkg::CCC_LEFT_ALIGN_BIT];
               next_state.channel_select    = wdata_i[ccc_pkg::CCC_CHANNEL_LSB +: 6];
            end
            ccc_pkg::CCC_ADDR_POWER: begin
               next_state.conv_power_gate = wdata_i[ccc_pkg::CCC_POWER_GATE_BIT];
            end
            default: begin
            end
         endcase
      end

      // Selections pass to the analog side only while enabled
      if (state.conv_enable) begin
         next_state.eff_reference = state.reference_select;
         next_state.eff_channel   = state.channel_select;
      end

      // Register reads, data in following cycle
      if (rd_i) begin
         case (addr_i)
            ccc_pkg::CCC_ADDR_CMP_CTRL: begin
               next_state.rdata = {2'h0, cmp_sync_output, state.cmp_irq_flag,
                  state.cmp_irq_enable, state.cmp_capture_route, state.cmp_event_select};
            end
            ccc_pkg::CCC_ADDR_CONV_CTRL_B: begin
               next_state.rdata = {1'b0, state.cmp_negative_mux_enable, 6'h00};
            end
            ccc_pkg::CCC_ADDR_PIN_DISABLE: begin
               next_state.rdata = {6'h00, state.neg_pin_input_off, state.pos_pin_input_off};
            end
            ccc_pkg::CCC_ADDR_CONV_CTRL_A: begin
               next_state.rdata = {state.conv_enable, 3'h0, state.conv_irq_flag,
                  state.conv_irq_enable, 2'h0};
            end
            ccc_pkg::CCC_ADDR_CHAN_REF: begin
               next_state.rdata = {state.reference_select, state.result_left_align,
                  state.channel_select[4:0]};
            end
            ccc_pkg::CCC_ADDR_RESULT_LOW: begin
               next_state.rdata         = res_low;
               next_state.result_locked = 1'b1;
            end
            ccc_pkg::CCC_ADDR_RESULT_HIGH: begin
               next_state.rdata         = res_high;
               next_state.result_locked = 1'b0;
            end
            ccc_pkg::CCC_ADDR_POWER: begin
               next_state.rdata = {7'h00, state.conv_power_gate};
            end
            default: begin
               next_state.rdata = ccc_pkg::CCC_RESET_BYTE;
            end
         endcase
      end

      // Conversion completion: flag always, result only when unlocked
      if (conv_done_i && conv_active) begin
         next_state.conv_irq_flag = 1'b1;
         if (!state.result_locked) begin
            next_state.result = conv_result_i;
         end
      end

      // Comparator flag: hardware clear by vector, set wins over any clear
      if (cmp_vector_ack_i) begin
         next_state.cmp_irq_flag = 1'b0;
      end
      if (cmp_event) begin
         next_state.cmp_irq_flag = 1'b1;
      end
   end

   // State register
   always_ff @(posedge ref_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         state                 <= '0;
         state.conv_power_gate <= ccc_pkg::CCC_POWER_RESET[0];
         state.result          <= ccc_pkg::CCC_RESULT_RESET;
      end else begin
         state <= next_state;
      end
   end

   // ==========================================================================================
   // Outputs
   assign rdata_o             = state.rdata;
   assign cmp_irq_o           = state.cmp_irq_flag && state.cmp_irq_enable
                                && global_irq_enable_i;
   assign conv_irq_o          = state.conv_irq_flag && state.conv_irq_enable
                                && global_irq_enable_i;
   assign capture_input_o     = state.cmp_capture_route && cmp_sync_output;
   assign pos_pin_port_o      = state.pin_meta[1] && !state.pos_pin_input_off;
   assign neg_pin_port_o      = state.pin_meta[0] && !state.neg_pin_input_off;
   assign pos_pin_buffer_on_o = !state.pos_pin_input_off;
   assign neg_pin_buffer_on_o = !state.neg_pin_input_off;
   assign conv_active_o       = conv_active;
   assign reference_select_o  = state.eff_reference;
   assign channel_select_o    = state.eff_channel;
endmodule

// ---- common/ccc_pkg.sv ----
// Package with register map, field positions, reset values and codes for the converter control
// ============================================================================================
// How it works
// - Comparator interrupt raised only when its enable and global enable are both set.
// - Capture routing bit connects comparator output to timer capture front-end.
// - Event select: 0 toggle, 1 reserved, 2 falling, 3 rising edge.
// - Mux enable with converter off picks channel mux as negative input.
// - Pin input-disable bits turn off buffers and force port bits to zero.
// - Result is 10 bits, ground 0x000, reference minus one LSB 0x3FF.
// - Reference select picks 1.5V, 1.6V, analog supply or external reference.
// - Reference and channel selections take effect only while converter enabled.
// - Result right-aligned by default, left-aligned when alignment bit set.
// - Low byte read blocks result updates; completing conversions then discarded.
// - High byte read re-enables result updates.
// - Completion interrupt fires on every conversion, even discarded ones.
// - Converter usable only while its power gate bit is zero.
// - Gain pairs apply programmable gain of 1x, 10x or 200x.
// - Single-ended channels bypass the gain amplifier.
// - Comparator flag set on event, cleared by vector or writing one.
// - Comparator output bit is synchronized copy, lagging one to two cycles.
package ccc_pkg;
   // ==========================================================================================
   // Register offsets (byte addresses on the local port)
   localparam logic [7:0] CCC_ADDR_CONV_CTRL_B   = 8'h7B;
   localparam logic [7:0] CCC_ADDR_CMP_CTRL      = 8'h50;
   localparam logic [7:0] CCC_ADDR_PIN_DISABLE   = 8'h7F;
   localparam logic [7:0] CCC_ADDR_CONV_CTRL_A   = 8'h7A;
   localparam logic [7:0] CCC_ADDR_CHAN_REF      = 8'h7C;
   localparam logic [7:0] CCC_ADDR_RESULT_LOW    = 8'h78;
   localparam logic [7:0] CCC_ADDR_RESULT_HIGH   = 8'h79;
   localparam logic [7:0] CCC_ADDR_POWER         = 8'h64;
   // ==========================================================================================
   // Field positions
   localparam int CCC_CMP_IRQ_FLAG_BIT     = 4;
   localparam int CCC_CMP_SYNC_OUT_BIT     = 5;
   localparam int CCC_CMP_IRQ_ENABLE_BIT   = 3;
   localparam int CCC_CMP_CAPTURE_BIT      = 2;
   localparam int CCC_CMP_EVENT_LSB        = 0;
   localparam int CCC_CMP_MUX_ENABLE_BIT   = 6;
   localparam int CCC_NEG_PIN_OFF_BIT      = 1;
   localparam int CCC_POS_PIN_OFF_BIT      = 0;
   localparam int CCC_CONV_ENABLE_BIT      = 7;
   localparam int CCC_CONV_IRQ_FLAG_BIT    = 4;
   localparam int CCC_CONV_IRQ_ENABLE_BIT  = 3;
   localparam int CCC_REF_SELECT_LSB       = 6;
   localparam int CCC_LEFT_ALIGN_BIT       = 5;
   localparam int CCC_CHANNEL_LSB          = 0;
   localparam int CCC_POWER_GATE_BIT       = 0;
   // ==========================================================================================
   // Reset values and codes
   localparam logic [7:0] CCC_RESET_BYTE   = 8'h00;
   localparam logic [7:0] CCC_POWER_RESET  = 8'h01;
   localparam logic [9:0] CCC_RESULT_RESET = 10'h000;
   localparam logic [9:0] CCC_RESULT_MAX   = 10'h3FF;
   localparam logic [1:0] CCC_EVT_TOGGLE   = 2'h0;
   localparam logic [1:0] CCC_EVT_RESERVED = 2'h1;
   localparam logic [1:0] CCC_EVT_FALLING  = 2'h2;
   localparam logic [1:0] CCC_EVT_RISING   = 2'h3;
   // Reference codes: external, supply, 1.5V, 1.6V
   localparam logic [1:0] CCC_REF_EXTERNAL = 2'h0;
   localparam logic [1:0] CCC_REF_SUPPLY   = 2'h1;
   localparam logic [1:0] CCC_REF_1V5      = 2'h2;
   localparam logic [1:0] CCC_REF_1V6      = 2'h3;
   // Gain codes
   localparam logic [1:0] CCC_GAIN_BYPASS  = 2'h0;
   localparam logic [1:0] CCC_GAIN_X1      = 2'h1;
   localparam logic [1:0] CCC_GAIN_X10     = 2'h2;
   localparam logic [1:0] CCC_GAIN_X200    = 2'h3;
endpackage

// ---- hw/ccc_sync.sv ----
// Two-flop synchroniser for asynchronous single-bit inputs
`timescale 1ns/10ps
module ccc_sync #(
   parameter int WIDTH = 1
) (
   // Clock and reset
   input  wire logic             ref_clk_i,
   input  wire logic             nrst_i,
   // Data
   input  wire logic [WIDTH-1:0] async_i,
   output logic      [WIDTH-1:0] sync_o
);
   typedef struct packed {
      logic [WIDTH-1:0] meta;
      logic [WIDTH-1:0] stable;
   } ccc_sync_state_t;

   ccc_sync_state_t state;
   ccc_sync_state_t next_state;

   // Refuse at elaboration a width that no flop could hold
   if (WIDTH < 1) begin
      $error("ccc_sync width must be at least one");
   end

   // First flop feeds only the second
   always_comb begin
      next_state.meta   = async_i;
      next_state.stable = state.meta;
   end

   // State register
   always_ff @(posedge ref_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         state <= '0;
      end else begin
         state <= next_state;
      end
   end

   assign sync_o = state.stable;
endmodule

// ---- hw/ccc_chan_decode.sv ----
// Channel decode: negative input source and gain setting
`timescale 1ns/10ps
module ccc_chan_decode (
   // Selection
   input  wire logic [5:0] channel_select_i,
   input  wire logic       conv_enable_i,
   input  wire logic       cmp_negative_mux_enable_i,
   // Decode results
   output logic            use_mux_negative_o,
   output logic [2:0]      mux_negative_chan_o,
   output logic [1:0]      gain_o
);
   // Comparator negative input from channel mux only with converter off
   always_comb begin
      use_mux_negative_o  = cmp_negative_mux_enable_i && !conv_enable_i;
      mux_negative_chan_o = channel_select_i[2:0];
   end

   // Gain pairs: codes 0x08-0x0F are pair 1/0, 0x28-0x2F pair 3/2 style grouping
   always_comb begin
      if (channel_select_i[5:3] == 3'h0) begin
         gain_o = ccc_pkg::CCC_GAIN_BYPASS;
      end else if (channel_select_i[3] == 1'b1) begin
         case (channel_select_i[2:1])
            2'h0:    gain_o = ccc_pkg::CCC_GAIN_X10;
            2'h1:    gain_o = ccc_pkg::CCC_GAIN_X200;
            default: gain_o = ccc_pkg::CCC_GAIN_X1;
         endcase
      end else begin
         gain_o = ccc_pkg::CCC_GAIN_X1;
      end
   end
endmodule

// ---- tb/ccc_props.sv ----
// Concurrent checks on the converter control top-level ports
`timescale 1ns/10ps
module ccc_props (
   // Clock and reset
   input wire logic       ref_clk_i,
   input wire logic       nrst_i,
   // Observed ports
   input wire logic       rd_i,
   input wire logic [7:0] rdata_o,
   input wire logic       global_irq_enable_i,
   input wire logic       cmp_irq_o,
   input wire logic       conv_irq_o,
   input wire logic       cmp_analog_i,
   input wire logic       capture_input_o,
   input wire logic       pos_pin_port_o,
   input wire logic       neg_pin_port_o,
   input wire logic       pos_pin_buffer_on_o,
   input wire logic       neg_pin_buffer_on_o,
   input wire logic       use_mux_negative_o,
   input wire logic [2:0] mux_negative_chan_o,
   input wire logic       conv_active_o,
   input wire logic [5:0] channel_select_o,
   input wire logic [1:0] gain_o
);
   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (!nrst_i);
   // ===========================================================================
   // Buffer-off held three cycles; the port is gated by the same off bit in the same cycle
   sequence s_pos_off;
      !pos_pin_buffer_on_o [*3];
   endsequence
   sequence s_neg_off;
      !neg_pin_buffer_on_o [*3];
   endsequence
   // ===========================================================================
   // Port relations
   a_cmp_irq_gate: assert property (cmp_irq_o |-> global_irq_enable_i)
      else $error("comparator request without global enable");
   a_conv_irq_gate: assert property (conv_irq_o |-> global_irq_enable_i)
      else $error("converter request without global enable");
   a_capture_src: assert property (capture_input_o |->
      ($past(cmp_analog_i, 1) || $past(cmp_analog_i, 2) || $past(cmp_analog_i, 3)))
      else $error("capture input high without comparator high");
   a_mux_conv_off: assert property (use_mux_negative_o |-> !conv_active_o)
      else $error("mux negative input while converter active");
   a_mux_chan_copy: assert property (use_mux_negative_o |->
      mux_negative_chan_o == channel_select_o[2:0])
      else $error("mux negative channel mismatch");
   a_pos_pin_zero: assert property (s_pos_off |-> !pos_pin_port_o)
      else $error("positive pin port not forced low");
   a_neg_pin_zero: assert property (s_neg_off |-> !neg_pin_port_o)
      else $error("negative pin port not forced low");
   a_gain_bypass: assert property (channel_select_o[5:3] == 3'h0 |->
      gain_o == ccc_pkg::CCC_GAIN_BYPASS)
      else $error("single-ended channel not bypassing gain");
   a_rdata_idle: assert property (!$past(rd_i) |-> rdata_o == 8'h00)
      else $error("read data not zero outside read answer");
endmodule

// ---- tb/tb.sv ----
// Self-checking bench for the comparator and converter control block
`timescale 1ns/10ps
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin mismatches++; \
   $display("CHECK FAILED %s expected %0h seen %0h", n, e, g); end end
module tb;
   // ===========================================================================
   // Stimulus and observed signals
   logic       ref_clk_i = 1'b0;
   logic       nrst_i = 1'b0;
   logic [7:0] addr_i = 8'h00;
   logic [7:0] wdata_i = 8'h00;
   logic       wr_i = 1'b0;
   logic       rd_i = 1'b0;
   logic       global_irq_enable_i = 1'b1;
   logic       cmp_vector_ack_i = 1'b0;
   logic       cmp_analog_i = 1'b0;
   logic       cmp_positive_pin_i = 1'b0;
   logic       cmp_negative_pin_i = 1'b0;
   logic       conv_done_i = 1'b0;
   logic [9:0] conv_result_i = 10'h000;
   logic [7:0] rdata_o;
   logic       cmp_irq_o, conv_irq_o, capture_input_o, use_mux_negative_o, conv_active_o;
   logic       pos_pin_port_o, neg_pin_port_o, pos_pin_buffer_on_o, neg_pin_buffer_on_o;
   logic [2:0] mux_negative_chan_o;
   logic [1:0] reference_select_o, gain_o;
   logic [5:0] channel_select_o;
   int         mismatches = 0;
   int         comparisons = 0;
   // Clock at 200 MHz
   always #2.5 ref_clk_i = ~ref_clk_i;
   ccc_top DUT (.ref_clk_i, .nrst_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
      .global_irq_enable_i, .cmp_vector_ack_i, .cmp_irq_o, .conv_irq_o, .cmp_analog_i,
      .cmp_positive_pin_i, .cmp_negative_pin_i, .pos_pin_port_o, .neg_pin_port_o,
      .pos_pin_buffer_on_o, .neg_pin_buffer_on_o, .capture_input_o, .use_mux_negative_o,
      .mux_negative_chan_o, .conv_done_i, .conv_result_i, .conv_active_o,
      .reference_select_o, .channel_select_o, .gain_o);
   // ===========================================================================
   // Bus and timing helpers
   task automatic wt(input int n);
      repeat (n) @(posedge ref_clk_i);
      #1;
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge ref_clk_i);
      addr_i  <= a;
      wdata_i <= d;
      wr_i    <= 1'b1;
      @(posedge ref_clk_i);
      wr_i <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e, input string n);
      @(posedge ref_clk_i);
      addr_i <= a;
      rd_i   <= 1'b1;
      @(posedge ref_clk_i);
      rd_i <= 1'b0;
      #1;
      `CHK(n, e, rdata_o)
   endtask
   task automatic done(input logic [9:0] r);
      @(posedge ref_clk_i);
      conv_done_i   <= 1'b1;
      conv_result_i <= r;
      @(posedge ref_clk_i);
      conv_done_i <= 1'b0;
      wt(2);
   endtask
   // ===========================================================================
   // Scenarios
   task automatic t_reset;
      rd(ccc_pkg::CCC_ADDR_POWER, 8'h01, "power gate");
      rd(ccc_pkg::CCC_ADDR_CMP_CTRL, 8'h00, "cmp ctrl");
      rd(ccc_pkg::CCC_ADDR_CONV_CTRL_B, 8'h00, "ctrl b");
      wr(8'h00, 8'hFF);
      rd(8'h00, 8'h00, "unmapped");
      `CHK("buffer on", 1'b1, pos_pin_buffer_on_o)
   endtask
   task automatic t_cmp;
      logic [1:0] c;
      logic       fr;
      logic       ff;
      for (int i = 0; i < 4; i++) begin
         c  = 2'(i);
         fr = (c == ccc_pkg::CCC_EVT_TOGGLE) || (c == ccc_pkg::CCC_EVT_RISING);
         ff = (c == ccc_pkg::CCC_EVT_TOGGLE) || (c == ccc_pkg::CCC_EVT_FALLING);
         wr(ccc_pkg::CCC_ADDR_CMP_CTRL, 8'h10 | 8'(c));
         wr(ccc_pkg::CCC_ADDR_CMP_CTRL, 8'h08 | 8'(c));
         @(posedge ref_clk_i) cmp_analog_i <= 1'b1;
         wt(6);
         `CHK("irq on rise", fr, cmp_irq_o)
         rd(ccc_pkg::CCC_ADDR_CMP_CTRL, {2'b00, 1'b1, fr, 4'h8 | 4'(c)}, "status");
         @(posedge ref_clk_i) cmp_vector_ack_i <= 1'b1;
         @(posedge ref_clk_i) cmp_vector_ack_i <= 1'b0;
         wt(1);
         `CHK("ack clear", 1'b0, cmp_irq_o)
         @(posedge ref_clk_i) cmp_analog_i <= 1'b0;
         wt(6);
         `CHK("irq on fall", ff, cmp_irq_o)
         @(posedge ref_clk_i) global_irq_enable_i <= 1'b0;
         wt(1);
         `CHK("global gate", 1'b0, cmp_irq_o)
         @(posedge ref_clk_i) global_irq_enable_i <= 1'b1;
         wr(ccc_pkg::CCC_ADDR_CMP_CTRL, 8'(c));
         wt(1);
         `CHK("enable gate", 1'b0, cmp_irq_o)
         rd(ccc_pkg::CCC_ADDR_CMP_CTRL, {3'b000, ff, 4'(c)}, "flag kept");
      end
   endtask
   task automatic t_capture;
      wr(ccc_pkg::CCC_ADDR_CMP_CTRL, 8'h04);
      @(posedge ref_clk_i) cmp_analog_i <= 1'b1;
      wt(6);
      `CHK("capture on", 1'b1, capture_input_o)
      wr(ccc_pkg::CCC_ADDR_CMP_CTRL, 8'h10);
      wt(1);
      `CHK("capture off", 1'b0, capture_input_o)
      @(posedge ref_clk_i) cmp_analog_i <= 1'b0;
   endtask
   task automatic t_pins;
      @(posedge ref_clk_i) cmp_positive_pin_i <= 1'b1;
      @(posedge ref_clk_i) cmp_negative_pin_i <= 1'b1;
      wr(ccc_pkg::CCC_ADDR_CONV_CTRL_B, 8'h40);
      wt(5);
      `CHK("pos port", 1'b1, pos_pin_port_o)
      `CHK("mux used", 1'b1, use_mux_negative_o)
      wr(ccc_pkg::CCC_ADDR_PIN_DISABLE, 8'h03);
      wt(3);
      `CHK("pos off", 1'b0, pos_pin_port_o)
      `CHK("neg off", 1'b0, neg_pin_port_o)
      `CHK("neg buffer", 1'b0, neg_pin_buffer_on_o)
      wr(ccc_pkg::CCC_ADDR_POWER, 8'h00);
      wr(ccc_pkg::CCC_ADDR_CONV_CTRL_A, 8'h80);
      wt(1);
      `CHK("mux released", 1'b0, use_mux_negative_o)
      wr(ccc_pkg::CCC_ADDR_CONV_CTRL_A, 8'h00);
      wr(ccc_pkg::CCC_ADDR_PIN_DISABLE, 8'h00);
      wr(ccc_pkg::CCC_ADDR_CONV_CTRL_B, 8'h00);
   endtask
   task automatic t_conv;
      wr(ccc_pkg::CCC_ADDR_CHAN_REF, 8'hC9);
      wt(2);
      `CHK("ref held", 2'h0, reference_select_o)
      wr(ccc_pkg::CCC_ADDR_POWER, 8'h00);
      wr(ccc_pkg::CCC_ADDR_CONV_CTRL_A, 8'h88);
      wt(2);
      `CHK("ref taken", ccc_pkg::CCC_REF_1V6, reference_select_o)
      `CHK("chan taken", 6'h09, channel_select_o)
      `CHK("gain pair", ccc_pkg::CCC_GAIN_X10, gain_o)
      `CHK("conv active", 1'b1, conv_active_o)
      for (int i = 0; i < 4; i++) begin
         wr(ccc_pkg::CCC_ADDR_CHAN_REF, {2'(i), 6'h00});
         wt(2);
         `CHK("ref code", 2'(i), reference_select_o)
      end
      `CHK("gain bypass", ccc_pkg::CCC_GAIN_BYPASS, gain_o)
      done(10'h3FF);
      `CHK("done irq", 1'b1, conv_irq_o)
      rd(ccc_pkg::CCC_ADDR_RESULT_LOW, 8'hFF, "low right");
      rd(ccc_pkg::CCC_ADDR_RESULT_HIGH, 8'h03, "high right");
      wr(ccc_pkg::CCC_ADDR_CONV_CTRL_A, 8'h98);
      rd(ccc_pkg::CCC_ADDR_RESULT_LOW, 8'hFF, "low lock");
      done(10'h000);
      `CHK("lost irq", 1'b1, conv_irq_o)
      rd(ccc_pkg::CCC_ADDR_RESULT_HIGH, 8'h03, "high kept");
      wr(ccc_pkg::CCC_ADDR_CONV_CTRL_A, 8'h98);
      done(10'h2A5);
      wr(ccc_pkg::CCC_ADDR_CHAN_REF, 8'h20);
      rd(ccc_pkg::CCC_ADDR_RESULT_LOW, 8'h40, "low left");
      rd(ccc_pkg::CCC_ADDR_RESULT_HIGH, 8'hA9, "high left");
      wr(ccc_pkg::CCC_ADDR_CONV_CTRL_A, 8'h98);
      wr(ccc_pkg::CCC_ADDR_POWER, 8'h01);
      done(10'h155);
      `CHK("gated done", 1'b0, conv_irq_o)
      wr(ccc_pkg::CCC_ADDR_CONV_CTRL_A, 8'h00);
   endtask
   // ===========================================================================
   // Verdict and end of run
   task automatic test_done;
      $display("comparisons %0d mismatches %0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   // Main sequence after reset
   initial begin
      repeat (20) @(posedge ref_clk_i);
      nrst_i <= 1'b1;
      t_reset;
      t_cmp;
      t_capture;
      t_pins;
      t_conv;
      test_done;
   end
   // Watchdog well beyond the expected run length
   initial begin
      #100000;
      mismatches++;
      test_done;
   end
endmodule
bind ccc_top ccc_props u_props (.ref_clk_i, .nrst_i, .rd_i, .rdata_o, .global_irq_enable_i,
   .cmp_irq_o, .conv_irq_o, .cmp_analog_i, .capture_input_o, .pos_pin_port_o,
   .neg_pin_port_o, .pos_pin_buffer_on_o, .neg_pin_buffer_on_o, .use_mux_negative_o,
   .mux_negative_chan_o, .conv_active_o, .channel_select_o, .gain_o);
